// [design/adt_dcmp_trig_ctrl.sv]
// Purpose: software-driven trigger-history reset for comparator units 2..6
// Assumes: avalon-mm slave, 32-bit data, byte address, 200 MHz ref_clk
// Notes: trigger units are instantiated here so the reset acts on real state
// Operation
// - bit 22 write one resets unit six
// - bits 21..18 reset units five to two
// - bit self-clears once unit clearing finishes
// - trigger uses current and previous result
// - bits read/write, zero after reset
module adt_dcmp_trig_ctrl (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic [11:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [59:0] cmp_sample,
   input wire logic [4:0] cmp_sample_valid,
   input wire logic [59:0] cmp_threshold,
   output logic [4:0] cmp_trigger
);
   logic [4:0] pend_reg;
   logic [4:0] pend_next;
   logic [4:0] done_w;
   logic [4:0] hist_w;
   logic [4:0] trig_w;
   logic [31:0] rdata_reg;
   logic ack_reg;
   logic sel_ric;
   logic sel_stat;
   logic wr_ric;
   logic [4:0] set_w;
   logic [31:0] rd_mux;
   logic req;

   // one wait cycle per access gives a registered read path
   assign req = avs_read || avs_write;
   assign avs_waitrequest = req && !ack_reg;
   assign sel_ric = (avs_address == adt_pkg::RIC_OFFSET);
   assign sel_stat = (avs_address == adt_pkg::STAT_OFFSET);
   // bits 22..18 all sit in byte lane 2
   // the write lands only at the edge where waitrequest is low
   assign wr_ric = avs_write && ack_reg && sel_ric && avs_byteenable[2];
   // a zero bit sets nothing; software cannot cancel a pending reset
   assign set_w = wr_ric ? avs_writedata[adt_pkg::TRIG_MSB:adt_pkg::TRIG_LSB] : 5'h00;
   // set wins over the self-clear in the same cycle
   assign pend_next = set_w | (pend_reg & ~done_w);

   always_comb begin
      rd_mux = 32'h0000_0000;
      if (sel_ric) begin
         rd_mux[adt_pkg::TRIG_MSB:adt_pkg::TRIG_LSB] = pend_reg;
      end else if (sel_stat) begin
         rd_mux[4:0] = hist_w;
         rd_mux[12:8] = trig_w;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         pend_reg <= adt_pkg::TRIG_RESET_VAL;
         ack_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
      end else begin
         pend_reg <= pend_next;
         ack_reg <= req && !ack_reg;
         // capture once per read so the data stands until the next read
         if (avs_read && !ack_reg) begin
            rdata_reg <= rd_mux;
         end
      end
   end
   assign avs_readdata = rdata_reg;
   assign cmp_trigger = trig_w;

   genvar gi;
   generate
      for (gi = 0; gi < adt_pkg::NUM_UNITS; gi++) begin : g_unit
         adt_unit_if uif ();
         assign uif.clear_req = pend_reg[gi];
         assign uif.sample = cmp_sample[gi*12 +: 12];
         assign uif.sample_valid = cmp_sample_valid[gi];
         assign uif.threshold = cmp_threshold[gi*12 +: 12];
         assign done_w[gi] = uif.clear_done;
         assign hist_w[gi] = uif.history_valid;
         assign trig_w[gi] = uif.trigger;
         adt_trig_unit u_unit (
            .ref_clk(ref_clk),
            .nrst(nrst),
            .u(uif.unit)
         );
      end
   endgenerate

   // software is expected to reset units before each new sequence

   a_pend_sets: assert property (@(posedge ref_clk) disable iff (!nrst)
      wr_ric && avs_writedata[22] |=> pend_reg[4])
      else $error("bit 22 write did not set pending");
   a_low_sets: assert property (@(posedge ref_clk) disable iff (!nrst)
      wr_ric && avs_writedata[18] |=> pend_reg[0])
      else $error("bit 18 write did not set pending");
   a_self_clear: assert property (@(posedge ref_clk) disable iff (!nrst)
      $rose(pend_reg[4]) && !set_w[4] |=> ##[0:3] !pend_reg[4])
      else $error("pending bit did not self-clear");
   a_hist_flush: assert property (@(posedge ref_clk) disable iff (!nrst)
      done_w[2] |=> !hist_w[2])
      else $error("history kept after clear");
   a_zero_keeps: assert property (@(posedge ref_clk) disable iff (!nrst)
      wr_ric && !avs_writedata[19] && !pend_reg[1] |=> !pend_reg[1])
      else $error("zero write started a clear");
   a_read_pend: assert property (@(posedge ref_clk) disable iff (!nrst)
      avs_read && sel_ric && !avs_waitrequest |-> avs_readdata[22:18] == $past(pend_reg))
      else $error("read data does not show pending");
   a_reset_zero: assert property (@(posedge ref_clk)
      $rose(nrst) |-> pend_reg == 5'h00)
      else $error("pending not zero after reset");
   a_done_pend: assert property (@(posedge ref_clk) disable iff (!nrst)
      done_w[0] |-> pend_reg[0])
      else $error("clear done without pending");
   c_clear_u6: cover property (@(posedge ref_clk) disable iff (!nrst) done_w[4]);
   c_all_set: cover property (@(posedge ref_clk) disable iff (!nrst) pend_reg == 5'h1F);
   c_trig: cover property (@(posedge ref_clk) disable iff (!nrst) trig_w[0]);
   c_set_vs_clr: cover property (@(posedge ref_clk) disable iff (!nrst) set_w[1] && done_w[1]);
endmodule : adt_dcmp_trig_ctrl

// [design/adt_pkg.sv]
// Purpose: shared constants for the comparator trigger-reset control block
// Assumes: 32-bit avalon-mm register bus, 200 MHz ref_clk
// Notes: only trigger units 2..6 are handled here
package adt_pkg;
   localparam int NUM_UNITS = 5;
   localparam int FIRST_UNIT = 2;
   localparam int RES_W = 12;
   localparam int ADDR_W = 12;
   localparam logic [11:0] RIC_OFFSET = 12'hD00;
   localparam logic [11:0] STAT_OFFSET = 12'hD04;
   localparam int TRIG_LSB = 18;
   localparam int TRIG_MSB = 22;
   localparam logic [4:0] TRIG_RESET_VAL = 5'h00;
   localparam int CLR_CYCLES = 2;
   localparam logic [1:0] CLR_CNT_INIT = 2'h1;
   typedef enum logic [1:0] {
      ADT_IDLE,
      ADT_CLEAR,
      ADT_DONE
   } adt_clr_state_t;
endpackage : adt_pkg

// [design/adt_unit_if.sv]
// Purpose: bundle between controller and one comparator trigger unit
// Assumes: single clock domain
// Notes: clear_req is a level held until clear_done pulses
interface adt_unit_if;
   logic clear_req;
   logic clear_done;
   logic [11:0] sample;
   logic sample_valid;
   logic [11:0] threshold;
   logic trigger;
   logic history_valid;
   modport ctrl (output clear_req, input clear_done, input trigger, input history_valid);
   modport unit (input clear_req, output clear_done, input sample, input sample_valid,
      input threshold, output trigger, output history_valid);
endinterface : adt_unit_if

// [design/adt_trig_unit.sv]
// Purpose: one comparator trigger unit holding the previous result to compare with the current one
// Assumes: clear_req held high until clear_done
// Notes: trigger fires on an upward crossing of the threshold
module adt_trig_unit (
   input wire logic ref_clk,
   input wire logic nrst,
   adt_unit_if.unit u
);
   logic [11:0] prev_reg;
   logic hist_reg;
   logic trig_reg;
   logic [1:0] cnt_reg;
   logic clearing;
   logic crossing;
   assign clearing = u.clear_req;
   // needs both the held previous result and the new one
   assign crossing = hist_reg && (prev_reg < u.threshold) && (u.sample >= u.threshold);
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         prev_reg <= 12'h000;
         hist_reg <= 1'b0;
         trig_reg <= 1'b0;
         cnt_reg <= 2'h0;
      end else if (clearing) begin
         prev_reg <= 12'h000;
         hist_reg <= 1'b0;
         trig_reg <= 1'b0;
         cnt_reg <= (cnt_reg == 2'h0) ? adt_pkg::CLR_CNT_INIT : 2'h0;
      end else begin
         cnt_reg <= 2'h0;
         if (u.sample_valid) begin
            prev_reg <= u.sample;
            hist_reg <= 1'b1;
            trig_reg <= crossing;
         end
      end
   end
   // clearing takes two cycles; done on the second
   assign u.clear_done = clearing && (cnt_reg == adt_pkg::CLR_CNT_INIT);
   assign u.trigger = trig_reg;
   assign u.history_valid = hist_reg;
endmodule : adt_trig_unit

// [dv/tb_top.sv]
// Purpose: self-checking bench for the comparator trigger-reset control block
// Assumes: avalon-mm slave with waitrequest, trigger on upward threshold crossing
// Notes: all units get one shared sample value so expectations stay simple
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin mismatches++; \
   $display("mismatch %s expected %h seen %h", nm, exp, got); end end
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic ref_clk = 1'b0;
   logic nrst = 1'b0;
   logic [11:0] avs_address = 12'h000;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [3:0] avs_byteenable = 4'hF;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [59:0] cmp_sample = 60'h0;
   logic [4:0] cmp_sample_valid = 5'h00;
   logic [59:0] cmp_threshold = {5{12'h100}};
   logic [4:0] cmp_trigger;
   logic [31:0] rdata;
   int mismatches = 0;
   int checked = 0;
   always #2.5 ref_clk = ~ref_clk;
   adt_dcmp_trig_ctrl i_dut (.ref_clk(ref_clk), .nrst(nrst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .cmp_sample(cmp_sample),
      .cmp_sample_valid(cmp_sample_valid), .cmp_threshold(cmp_threshold),
      .cmp_trigger(cmp_trigger));
   task automatic close_out();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // one access; the request holds until waitrequest is sampled low
   task automatic bus(input logic rd, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= rd;
      avs_write <= !rd;
      do begin
         @(posedge ref_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 40);
      if (avs_waitrequest !== 1'b0) begin
         mismatches++;
         close_out();
      end
      rdata = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic feed(input logic [11:0] v);
      cmp_sample <= {5{v}};
      cmp_sample_valid <= 5'h1F;
      @(posedge ref_clk);
      cmp_sample_valid <= 5'h00;
      repeat (3) @(posedge ref_clk);
   endtask
   task automatic reset_values();
      bus(1'b1, adt_pkg::RIC_OFFSET, 32'h0);
      `CHK("reset reg after reset", 32'h0000_0000, rdata)
      bus(1'b1, 12'h010, 32'h0);
      `CHK("unmapped read", 32'h0000_0000, rdata)
   endtask
   task automatic zero_write();
      feed(12'h050);
      bus(1'b0, adt_pkg::RIC_OFFSET, 32'h0000_0000);
      bus(1'b1, adt_pkg::STAT_OFFSET, 32'h0);
      `CHK("history after zero write", 5'h1F, rdata[4:0])
      bus(1'b0, adt_pkg::STAT_OFFSET, 32'hFFFF_FFFF);
      bus(1'b1, adt_pkg::STAT_OFFSET, 32'h0);
      `CHK("history after status write", 5'h1F, rdata[4:0])
      avs_byteenable <= 4'hB;
      bus(1'b0, adt_pkg::RIC_OFFSET, 32'hFFFF_FFFF);
      avs_byteenable <= 4'hF;
      bus(1'b1, adt_pkg::RIC_OFFSET, 32'h0);
      `CHK("write without lane 2", 32'h0000_0000, rdata)
      bus(1'b1, adt_pkg::STAT_OFFSET, 32'h0);
      `CHK("history after masked write", 5'h1F, rdata[4:0])
   endtask
   // clearing one unit must kill only its crossing on the next sample
   task automatic each_unit();
      logic [4:0] m;
      for (int i = 0; i < 5; i++) begin
         m = 5'h01 << i;
         feed(12'h050);
         bus(1'b0, adt_pkg::RIC_OFFSET, 32'h1 << (adt_pkg::TRIG_LSB + i));
         repeat (6) @(posedge ref_clk);
         bus(1'b1, adt_pkg::RIC_OFFSET, 32'h0);
         `CHK("bit self-clear", 32'h0000_0000, rdata)
         bus(1'b1, adt_pkg::STAT_OFFSET, 32'h0);
         `CHK("history after clear", 5'h1F & ~m, rdata[4:0])
         feed(12'h200);
         `CHK("trigger after clear", ~m, cmp_trigger)
      end
   endtask
   task automatic write_all();
      feed(12'h050);
      bus(1'b0, adt_pkg::RIC_OFFSET, 32'hFFFF_FFFF);
      repeat (6) @(posedge ref_clk);
      bus(1'b1, adt_pkg::RIC_OFFSET, 32'h0);
      `CHK("all bits self-clear", 32'h0000_0000, rdata)
      bus(1'b1, adt_pkg::STAT_OFFSET, 32'h0);
      `CHK("all history cleared", 5'h00, rdata[4:0])
   endtask
   initial begin
      repeat (12) @(posedge ref_clk);
      nrst <= 1'b1;
      @(posedge ref_clk);
      reset_values();
      zero_write();
      each_unit();
      write_all();
      close_out();
   end
endmodule // tb_top
